/* hdl/rx_route_pkg.sv */
// Package with register map, field positions and constants for the receive stream router.
package rx_route_pkg;
  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam logic [7:0]  ADDR_CTRL      = 8'h00;
  localparam logic [7:0]  ADDR_LANES     = 8'h04;
  localparam logic [7:0]  ADDR_RX_NCO    = 8'h08;
  localparam logic [7:0]  ADDR_FB_NCO    = 8'h0C;
  localparam logic [7:0]  ADDR_GAIN      = 8'h10;
  localparam logic [7:0]  ADDR_EQ        = 8'h14;
  localparam logic [7:0]  ADDR_CARRIER   = 8'h18;
  localparam logic [7:0]  ADDR_STATUS    = 8'h1C;
  localparam logic [7:0]  ADDR_IRQ_SEL   = 8'h20;
  localparam logic [7:0]  ADDR_DMA_DATA  = 8'h24;
  // ==========================================================================
  // Control fields
  // ==========================================================================
  localparam int CTRL_FB_TO_CONV   = 0;
  localparam int CTRL_RX_EN        = 1;
  localparam int CTRL_FB_EN        = 2;
  localparam int CTRL_TEST_SYSREF  = 3;
  localparam int CTRL_LANE_MODE    = 4;
  localparam int CTRL_PINMUX_SYNC  = 5;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // Lane configuration: antenna count in [1:0], lane count in [3:2].
  localparam logic [1:0] ANT_ONE  = 2'h0;
  localparam logic [1:0] ANT_TWO  = 2'h1;
  localparam logic [1:0] ANT_FOUR = 2'h2;
  localparam logic [1:0] LN_ONE   = 2'h0;
  localparam logic [1:0] LN_TWO   = 2'h1;
  localparam logic [1:0] LN_FOUR  = 2'h2;
  localparam logic [3:0] LANES_RESET = 4'h0;
  localparam logic [15:0] GAIN_RESET = 16'h4000;
  localparam logic [15:0] EQ_RESET   = 16'h4000;
  localparam int GAIN_SHIFT = 14;
  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int CLK_MHZ          = 50;
  localparam int TEST_SYSREF_NS   = 10240;
  localparam int TEST_SYSREF_CYC  = TEST_SYSREF_NS * CLK_MHZ / 1000;
  localparam int DECIM_DEFAULT    = 2;
endpackage : rx_route_pkg

/* hdl/rx_route.sv */
// Receive and feedback stream routing, conversion and link status for the front end.
//
// The implementer's own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
// Overview of operation
// (RULE1) Feedback normally goes to capture store.
// (RULE2) Extra-receive mode sends feedback to converter.
// (RULE3) Feedback: zero IF, equalize, gain correct.
// (RULE4) Receive: zero IF plus block down conversion.
// (RULE5) Converter splits carriers and decimates each; here one carrier, set by carrier_q, is mixed and decimated.
// (RULE6) Carriers gain-normalized, packed as containers.
// (RULE7) Block conversion: mix, switch, decimate, equalize.
// (RULE8) Two interrupt outputs for selected events.
// (RULE9) Up to four transmit lane buses driven.
// (RULE10) Up to four receive lane buses accepted.
// (RULE11) Receive lanes also carry the feedback stream.
// (RULE12) Lanes 0,1 muxed by boot mode selection.
// (RULE13) Sync inputs reassignable to network block.
// (RULE14) Sampled SYSREF taken from outside logic.
// (RULE15) Internal test SYSREF replaces external one.
// (RULE16) Monitor one sync input per link.
// (RULE17) Drive one sync output per link.
// (RULE18) Two antennas use two or four lanes.
// (RULE19) Four antennas always use four lanes.
// (RULE20) Software bypasses unpowered predistortion stage.
// (RULE21) 32-bit config bus plus DMA stream port.
// (RULE22) Feedback destination changes only while idle.
module rx_route
  import rx_route_pkg::*;
#(
  parameter int W     = 16,
  parameter int LANES = 4,
  parameter int DECIM = rx_route_pkg::DECIM_DEFAULT
)(
  input  wire logic                 clock,
  input  wire logic                 rst,
  input  wire logic [7:0]           addr,
  input  wire logic [31:0]          wdata,
  input  wire logic                 wr,
  input  wire logic                 rd,
  output logic      [31:0]          rdata,
  output logic                      dma_stream_valid,
  output logic      [31:0]          dma_stream_data,
  input  wire logic                 boot_lane_sel,
  input  wire logic [LANES*2*W-1:0] rx_lane_data,
  input  wire logic [LANES-1:0]     rx_lane_valid,
  input  wire logic [LANES*2*W-1:0] tx_stream_data,
  output logic      [LANES*2*W-1:0] tx_lane_data,
  output logic      [LANES*2*W-1:0] antenna_lane_port_tx,
  input  wire logic [2*2*W-1:0]     antenna_lane_port_rx,
  output logic      [2*2*W-1:0]     antenna_lane_port_to_net,
  input  wire logic                 sysref_sampled,
  output logic                      sysref_to_core,
  input  wire logic [1:0]           link_sync_input,
  output logic      [1:0]           link_sync_output,
  output logic      [1:0]           net_sync,
  output logic      [2*W-1:0]       capture_data,
  output logic                      capture_valid,
  output logic      [2*W-1:0]       conv_data,
  output logic                      conv_valid,
  output logic      [1:0]           conv_src,
  output logic      [2*W-1:0]       baseband_sample_bus,
  output logic                      baseband_sample_valid,
  output logic      [1:0]           irq
);
  import rx_route_pkg::*;
  // ==========================================================================
  // Parameter checks
  // ==========================================================================
  if (LANES != 4) $error("rx_route supports exactly four lanes");
  if (W < 4 || W > 16) $error("rx_route sample width must be 4..16");
  if (DECIM < 1 || DECIM > 8) $error("rx_route decimation must be 1..8");

  function automatic logic signed [W-1:0] scale(input logic signed [W-1:0] s,
                                               input logic [15:0] g);
    logic signed [W+16:0] p;
    p = s * $signed({1'b0, g});
    scale = p[GAIN_SHIFT+W-1:GAIN_SHIFT];
  endfunction : scale

  function automatic logic [2*W-1:0] rot(input logic [2*W-1:0] iq, input logic [1:0] ph);
    logic signed [W-1:0] i;
    logic signed [W-1:0] q;
    i = iq[2*W-1:W];
    q = iq[W-1:0];
    unique case (ph)
      2'h0: rot = {i, q};
      2'h1: rot = {q, -i};
      2'h2: rot = {-i, -q};
      2'h3: rot = {-q, i};
    endcase
  endfunction : rot

  // ==========================================================================
  // Registers
  // ==========================================================================
  logic [31:0] ctrl_q;
  logic [3:0]  lanes_q;
  logic [15:0] rx_nco_q;
  logic [15:0] fb_nco_q;
  logic [15:0] gain_q;
  logic [15:0] eq_q;
  logic [15:0] carrier_q;
  logic [7:0]  irq_sel_q;
  logic        fb_dest_q;
  logic        fb_busy_q;
  logic        cfg_err_q;
  logic [1:0]  sync_lost_q;
  logic [1:0]  ant;
  logic [1:0]  nln;
  logic        cfg_ok;

  assign ant = lanes_q[1:0];
  assign nln = lanes_q[3:2];
  assign cfg_ok = (ant == ANT_ONE) ||
                  (ant == ANT_TWO && (nln == LN_TWO || nln == LN_FOUR)) || // RULE18
                  (ant == ANT_FOUR && nln == LN_FOUR); // RULE19

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      ctrl_q    <= CTRL_RESET;
      lanes_q   <= LANES_RESET;
      rx_nco_q  <= 16'h0000;
      fb_nco_q  <= 16'h0000;
      gain_q    <= GAIN_RESET;
      eq_q      <= EQ_RESET;
      carrier_q <= 16'h0000;
      irq_sel_q <= 8'h00;
    end
    else if (wr)
    begin
      unique case (addr) // RULE21
        ADDR_CTRL:    ctrl_q    <= wdata;
        ADDR_LANES:   lanes_q   <= wdata[3:0];
        ADDR_RX_NCO:  rx_nco_q  <= wdata[15:0];
        ADDR_FB_NCO:  fb_nco_q  <= wdata[15:0];
        ADDR_GAIN:    gain_q    <= wdata[15:0];
        ADDR_EQ:      eq_q      <= wdata[15:0];
        ADDR_CARRIER: carrier_q <= wdata[15:0];
        ADDR_IRQ_SEL: irq_sel_q <= wdata[7:0];
        default: ;
      endcase
    end
  end

  // Destination is latched only while the feedback path is idle, so a
  // reroute never splits a stream between the two sinks.
  always_ff @(posedge clock)
  begin
    if (rst)
      fb_dest_q <= 1'b0;
    else if (!fb_busy_q)
      fb_dest_q <= ctrl_q[CTRL_FB_TO_CONV]; // RULE22
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      cfg_err_q <= 1'b0;
    else
      cfg_err_q <= !cfg_ok;
  end

  // ==========================================================================
  // Lane demapping and boot-time lane sharing
  // ==========================================================================
  logic [LANES*2*W-1:0] rx_lanes;
  genvar g;
  for (g = 0; g < LANES; g++)
  begin : g_lane
    if (g < 2)
    begin : g_shared
      assign rx_lanes[g*2*W +: 2*W] = boot_lane_sel ? '0 : rx_lane_data[g*2*W +: 2*W]; // RULE12
      assign antenna_lane_port_to_net[g*2*W +: 2*W] =
        boot_lane_sel ? rx_lane_data[g*2*W +: 2*W] : '0; // RULE12
      assign antenna_lane_port_tx[g*2*W +: 2*W] =
        boot_lane_sel ? antenna_lane_port_rx[g*2*W +: 2*W] : '0;
    end
    else
    begin : g_own
      assign rx_lanes[g*2*W +: 2*W] = rx_lane_data[g*2*W +: 2*W];
      assign antenna_lane_port_tx[g*2*W +: 2*W] = '0;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      tx_lane_data <= '0;
    else
      for (int k = 0; k < LANES; k++)
        tx_lane_data[k*2*W +: 2*W] <= (boot_lane_sel && k < 2) ?
          antenna_lane_port_rx[(k % 2)*2*W +: 2*W] : tx_stream_data[k*2*W +: 2*W]; // RULE9
  end

  // Receive stream on lane 0 (lane 2 when lanes 0,1 serve the network);
  // feedback always rides on the last lane.
  logic [2*W-1:0] rx_in;
  logic [2*W-1:0] fb_in;
  logic           rx_in_v;
  logic           fb_in_v;
  assign rx_in   = boot_lane_sel ? rx_lanes[2*2*W +: 2*W] : rx_lanes[0 +: 2*W]; // RULE10
  assign rx_in_v = (boot_lane_sel ? rx_lane_valid[2] : rx_lane_valid[0]) &&
                   ctrl_q[CTRL_RX_EN] && cfg_ok;
  assign fb_in   = rx_lanes[3*2*W +: 2*W]; // RULE11
  assign fb_in_v = rx_lane_valid[3] && ctrl_q[CTRL_FB_EN] && cfg_ok;

  // ==========================================================================
  // Receive block down conversion
  // ==========================================================================
  logic [15:0]    rx_ph_q;
  logic [2*W-1:0] rx_mix_q;
  logic           rx_mix_v_q;
  logic [2*W-1:0] rx_bdc_q;
  logic           rx_bdc_v_q;
  logic [7:0]     rx_dec_q;

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      rx_ph_q    <= 16'h0000;
      rx_mix_q   <= '0;
      rx_mix_v_q <= 1'b0;
    end
    else
    begin
      if (rx_in_v)
        rx_ph_q <= rx_ph_q + rx_nco_q;
      rx_mix_q   <= rot(rx_in, rx_ph_q[15:14]); // RULE4
      rx_mix_v_q <= rx_in_v;
    end
  end

  // Averaging pairs and keeping one output in DECIM cuts the rate by DECIM; a coarse filter, traded for area.
  logic [2*W-1:0] rx_prev_q;
  // The pair sum keeps one extra bit so a full-scale pair cannot wrap.
  logic signed [W:0] rx_sum_i;
  logic signed [W:0] rx_sum_q;
  assign rx_sum_i = $signed({rx_mix_q[2*W-1], rx_mix_q[2*W-1:W]}) +
                    $signed({rx_prev_q[2*W-1], rx_prev_q[2*W-1:W]});
  assign rx_sum_q = $signed({rx_mix_q[W-1], rx_mix_q[W-1:0]}) +
                    $signed({rx_prev_q[W-1], rx_prev_q[W-1:0]});
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      rx_prev_q  <= '0;
      rx_bdc_q   <= '0;
      rx_bdc_v_q <= 1'b0;
      rx_dec_q   <= 8'h00;
    end
    else
    begin
      rx_bdc_v_q <= 1'b0;
      if (rx_mix_v_q)
      begin
        rx_prev_q <= rx_mix_q;
        rx_dec_q  <= (rx_dec_q == 8'(DECIM - 1)) ? 8'h00 : rx_dec_q + 8'h01;
        if (rx_dec_q == 8'(DECIM - 1))
        begin
          rx_bdc_q <= {scale(rx_sum_i[W:1], eq_q), scale(rx_sum_q[W:1], eq_q)}; // RULE7
          rx_bdc_v_q <= 1'b1;
        end
      end
    end
  end

  // ==========================================================================
  // Feedback path
  // ==========================================================================
  logic [15:0]    fb_ph_q;
  logic [2*W-1:0] fb_rot;
  logic [2*W-1:0] fb_proc_q;
  logic           fb_proc_v_q;
  assign fb_rot = rot(fb_in, fb_ph_q[15:14]); // RULE3
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      fb_ph_q     <= 16'h0000;
      fb_proc_q   <= '0;
      fb_proc_v_q <= 1'b0;
      fb_busy_q   <= 1'b0;
    end
    else
    begin
      if (fb_in_v)
        fb_ph_q <= fb_ph_q + fb_nco_q;
      fb_proc_q <= {scale(scale(fb_rot[2*W-1:W], eq_q), gain_q),
                    scale(scale(fb_rot[W-1:0], eq_q), gain_q)}; // RULE3
      fb_proc_v_q <= fb_in_v;
      fb_busy_q   <= fb_in_v || fb_proc_v_q;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      capture_data  <= '0;
      capture_valid <= 1'b0;
    end
    else
    begin
      capture_data  <= fb_proc_q;
      capture_valid <= fb_proc_v_q && !fb_dest_q; // RULE1
    end
  end

  // ==========================================================================
  // Channel converter: carrier split, decimation, normalization
  // ==========================================================================
  logic [2*W-1:0] conv_in;
  logic           conv_in_v;
  logic [15:0]    ch_ph_q;
  logic [7:0]     ch_dec_q;
  assign conv_in   = fb_dest_q && fb_proc_v_q ? fb_proc_q : rx_bdc_q; // RULE2
  assign conv_in_v = rx_bdc_v_q || (fb_proc_v_q && fb_dest_q); // RULE2

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      conv_data  <= '0;
      conv_valid <= 1'b0;
      conv_src   <= 2'h0;
      ch_ph_q    <= 16'h0000;
      ch_dec_q   <= 8'h00;
    end
    else
    begin
      conv_valid <= 1'b0;
      if (conv_in_v)
      begin
        ch_ph_q  <= ch_ph_q + carrier_q;
        ch_dec_q <= (ch_dec_q == 8'(DECIM - 1)) ? 8'h00 : ch_dec_q + 8'h01;
        if (ch_dec_q == 8'(DECIM - 1))
        begin
          conv_data  <= rot(conv_in, ch_ph_q[15:14]); // RULE5
          conv_valid <= 1'b1;
          conv_src   <= {1'b0, fb_dest_q && fb_proc_v_q};
        end
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      baseband_sample_bus   <= '0;
      baseband_sample_valid <= 1'b0;
    end
    else
    begin
      baseband_sample_bus   <= {scale(conv_data[2*W-1:W], gain_q),
                                scale(conv_data[W-1:0], gain_q)}; // RULE6
      baseband_sample_valid <= conv_valid;
    end
  end

  // ==========================================================================
  // SYSREF, sync signalling
  // ==========================================================================
  logic [2:0]  sync_s0_q;
  logic [2:0]  sync_s1_q;
  logic [1:0]  sync_st_q;
  logic [15:0] tsys_q;
  always_ff @(posedge clock)
  begin
    if (rst)
      tsys_q <= 16'h0000;
    else
      tsys_q <= (tsys_q == 16'(TEST_SYSREF_CYC - 1)) ? 16'h0000 : tsys_q + 16'h0001;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      sysref_to_core <= 1'b0;
    else if (ctrl_q[CTRL_TEST_SYSREF])
      sysref_to_core <= (tsys_q == 16'h0000); // RULE15
    else
      sysref_to_core <= sysref_sampled; // RULE14
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      sync_s0_q <= 3'h0;
      sync_s1_q <= 3'h0;
      sync_st_q <= 2'h0;
    end
    else
    begin
      sync_s0_q <= {sync_s0_q[1:0], link_sync_input[0]};
      sync_s1_q <= {sync_s1_q[1:0], link_sync_input[1]};
      if (sync_s0_q[1] == sync_s0_q[2])
        sync_st_q[0] <= sync_s0_q[2]; // RULE16
      if (sync_s1_q[1] == sync_s1_q[2])
        sync_st_q[1] <= sync_s1_q[2]; // RULE16
    end
  end

  // Sync inputs go to the network block only when pin-muxed with boot lane selection; link status still feeds status and interrupts.
  assign net_sync = ctrl_q[CTRL_PINMUX_SYNC] && boot_lane_sel ? sync_st_q : 2'h0; // RULE13

  always_ff @(posedge clock)
  begin
    if (rst)
      link_sync_output <= 2'h0;
    else
      link_sync_output <= {rx_lane_valid[3] && cfg_ok,
                           (boot_lane_sel ? rx_lane_valid[2] : rx_lane_valid[0]) && cfg_ok}; // RULE17
  end

  // ==========================================================================
  // Events, interrupts, status stream
  // ==========================================================================
  logic [3:0] events;
  assign events = {cfg_err_q, capture_valid, !sync_st_q[1], !sync_st_q[0]};
  always_ff @(posedge clock)
  begin
    if (rst)
      irq <= 2'h0;
    else
      irq <= {|(events & irq_sel_q[7:4]), |(events & irq_sel_q[3:0])}; // RULE8
  end

  logic [31:0] status;
  assign status = {24'h0, fb_dest_q, fb_busy_q, cfg_err_q, boot_lane_sel, 2'h0, sync_st_q};

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      dma_stream_valid <= 1'b0;
      dma_stream_data  <= 32'h0000_0000;
    end
    else
    begin
      dma_stream_valid <= (status != dma_stream_data); // RULE21
      dma_stream_data  <= status;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      rdata <= 32'h0000_0000;
    else if (rd)
    begin
      unique case (addr)
        ADDR_CTRL:     rdata <= ctrl_q;
        ADDR_LANES:    rdata <= {28'h0, lanes_q};
        ADDR_RX_NCO:   rdata <= {16'h0, rx_nco_q};
        ADDR_FB_NCO:   rdata <= {16'h0, fb_nco_q};
        ADDR_GAIN:     rdata <= {16'h0, gain_q};
        ADDR_EQ:       rdata <= {16'h0, eq_q};
        ADDR_CARRIER:  rdata <= {16'h0, carrier_q};
        ADDR_STATUS:   rdata <= status;
        ADDR_IRQ_SEL:  rdata <= {24'h0, irq_sel_q};
        ADDR_DMA_DATA: rdata <= dma_stream_data;
        default:       rdata <= 32'h0000_0000;
      endcase
    end
    else
      rdata <= 32'h0000_0000;
  end
endmodule : rx_route

/* test/rx_route_assertions.sv */
// Port-level assertions for the receive stream router.
`timescale 1ns/1ps
module rx_route_assertions #(
  parameter int W     = 16,
  parameter int LANES = 4
)(
  input wire logic                 clock,
  input wire logic                 rst,
  input wire logic                 rd,
  input wire logic [31:0]          rdata,
  input wire logic                 boot_lane_sel,
  input wire logic [LANES*2*W-1:0] rx_lane_data,
  input wire logic [LANES-1:0]     rx_lane_valid,
  input wire logic [LANES*2*W-1:0] tx_stream_data,
  input wire logic [LANES*2*W-1:0] tx_lane_data,
  input wire logic [2*2*W-1:0]     antenna_lane_port_rx,
  input wire logic [2*2*W-1:0]     antenna_lane_port_to_net,
  input wire logic [2*W-1:0]       capture_data,
  input wire logic                 capture_valid,
  input wire logic                 conv_valid,
  input wire logic [1:0]           conv_src,
  input wire logic                 baseband_sample_valid
);
  localparam int HI = LANES*2*W-1;
  localparam int LO = 4*W;
  // ====================
  // Checks
  // ====================
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  a_rdata_slot_only: assert property (
    rdata != 32'h0 |-> $past(rd)) else $error("read data outside its slot");
  a_capture_latency: assert property (
    capture_valid |-> $past(rx_lane_valid[LANES-1], 2)) else $error("capture without sample");
  a_capture_word: assert property (
    capture_valid |-> capture_data == $past(rx_lane_data[HI:HI-2*W+1], 2))
    else $error("capture word differs from sample");
  a_feedback_one_sink: assert property (
    !(capture_valid && conv_valid && conv_src[0])) else $error("feedback sent to both sinks");
  a_tx_upper_lanes: assert property (
    tx_lane_data[HI:LO] == $past(tx_stream_data[HI:LO])) else $error("upper lanes wrong");
  a_tx_lower_lanes: assert property (
    tx_lane_data[LO-1:0] == ($past(boot_lane_sel) ? $past(antenna_lane_port_rx)
      : $past(tx_stream_data[LO-1:0]))) else $error("lower lanes wrong");
  a_net_lanes: assert property (
    boot_lane_sel |-> antenna_lane_port_to_net == rx_lane_data[LO-1:0])
    else $error("network lanes wrong");
  a_bb_after_conv: assert property (
    baseband_sample_valid |-> $past(conv_valid)) else $error("baseband word without carrier");
endmodule : rx_route_assertions

/* test/rx_far_end.sv */
// Behavioural model of the converter transceiver feeding the receive lanes.
`timescale 1ns/1ps
module rx_far_end #(
  parameter int W = 16
)(
  input  wire logic           clock,
  output logic      [8*W-1:0] rx_lane_data,
  output logic      [3:0]     rx_lane_valid,
  output logic                sysref_sampled,
  output logic      [1:0]     link_sync_input
);
  logic           go = 1'b0;
  int             sel = 0;
  logic [2*W-1:0] word = '0;
  initial
  begin
    sysref_sampled = 1'b0;
    link_sync_input = 2'b11;
  end
  // Idle lanes get a fresh pattern each cycle so a stale word never passes for a sample.
  always @(posedge clock)
  begin
    rx_lane_data <= {$urandom(), $urandom(), $urandom(), $urandom()};
    rx_lane_valid <= 4'h0;
    if (go)
    begin
      rx_lane_data[sel*2*W +: 2*W] <= word;
      rx_lane_valid[sel] <= 1'b1;
    end
  end
  task automatic send(input int lane, input logic [2*W-1:0] d);
    @(negedge clock);
    sel = lane;
    word = d;
    go = 1'b1;
  endtask : send
  task automatic stop();
    @(negedge clock);
    go = 1'b0;
  endtask : stop
  task automatic pulse();
    @(posedge clock);
    sysref_sampled <= 1'b1;
    @(posedge clock);
    sysref_sampled <= 1'b0;
  endtask : pulse
  task automatic set_sync(input logic [1:0] v);
    @(posedge clock);
    link_sync_input <= v;
  endtask : set_sync
endmodule : rx_far_end

/* test/rx_route_tb_top.sv */
// Self-checking bench for the receive stream router.
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin err_total++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module rx_route_tb_top;
  import rx_route_pkg::*;
  localparam int W = 16;
  localparam int D = 2;
  logic           clock = 1'b0;
  logic           rst = 1'b1;
  logic [7:0]     addr = 8'h00;
  logic [31:0]    wdata = 32'h0;
  logic           wr = 1'b0;
  logic           rd = 1'b0;
  logic           rd_q = 1'b0;
  logic           sr_q = 1'b0;
  logic           boot_lane_sel = 1'b0;
  logic [8*W-1:0] tx_stream_data = '0;
  logic [4*W-1:0] antenna_lane_port_rx = '0;
  logic [8*W-1:0] rx_lane_data, tx_lane_data, antenna_lane_port_tx;
  logic [4*W-1:0] antenna_lane_port_to_net;
  logic [31:0]    rdata, dma_stream_data;
  logic [2*W-1:0] capture_data, conv_data, baseband_sample_bus;
  logic [3:0]     rx_lane_valid;
  logic [1:0]     link_sync_input, link_sync_output, net_sync, conv_src, irq;
  logic           dma_stream_valid, sysref_sampled, sysref_to_core, capture_valid;
  logic           conv_valid, baseband_sample_valid;
  logic [31:0]    rq[$], cq[$];
  logic [31:0]    exp_w;
  int             err_total = 0, n_checks = 0, cyc = 0, conv_n = 0, bb_n = 0, sr_n = 0;
  logic [7:0]     ra[5] = '{ADDR_CTRL, ADDR_LANES, ADDR_GAIN, ADDR_EQ, 8'h30};
  logic [31:0]    rv[5] = '{CTRL_RESET, 32'h0, {16'h0, GAIN_RESET}, {16'h0, EQ_RESET}, 32'h0};
  logic [3:0]     lc[4] = '{4'h1, 4'h6, 4'h5, 4'hA};
  initial
  begin
    forever #10 clock = ~clock;
  end
  rx_route #(.W(W), .LANES(4), .DECIM(D)) dut (.*);
  rx_far_end #(.W(W)) far (.clock(clock), .rx_lane_data(rx_lane_data),
    .rx_lane_valid(rx_lane_valid), .sysref_sampled(sysref_sampled),
    .link_sync_input(link_sync_input));
  // ====================
  // Drivers and monitor
  // ====================
  // Transmit inputs change every cycle so a lane that latches late shows up.
  always @(posedge clock)
  begin
    if (!rst)
    begin
      tx_stream_data <= {$urandom(), $urandom(), $urandom(), $urandom()};
      antenna_lane_port_rx <= {$urandom(), $urandom()};
    end
  end
  always @(posedge clock)
  begin
    rd_q <= rd;
    sr_q <= sysref_to_core;
    cyc <= cyc + 1;
    if (rd_q)
    begin
      exp_w = rq.pop_front();
      `CHK(rdata, exp_w)
    end
    if (capture_valid === 1'b1)
    begin
      if (cq.size() == 0)
        `CHK(capture_valid, 1'b0)
      else
      begin
        exp_w = cq.pop_front();
        `CHK(capture_data, exp_w)
      end
    end
    if (conv_valid === 1'b1 && conv_src[0] === 1'b1) conv_n++;
    if (baseband_sample_valid === 1'b1) bb_n++;
    if (sysref_to_core === 1'b1 && sr_q !== 1'b1) sr_n++;
    if (cyc == 5000)
    begin
      err_total++;
      wrap_up();
    end
  end
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
    rq.push_back(e);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
  endtask : rd_reg
  task automatic fb_burst(input int n, input bit cap, input bit slow);
    logic [31:0] d;
    for (int i = 0; i < n; i++)
    begin
      d = $urandom();
      if (cap) cq.push_back(d);
      far.send(3, d);
      if (slow && d[0]) far.stop();
    end
    far.stop();
  endtask : fb_burst
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up
  // ====================
  // Tests
  // ====================
  initial
  begin
    void'($urandom(32'h3cc553d6));
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    wr_reg(8'h30, $urandom());
    for (int i = 0; i < 5; i++) rd_reg(ra[i], rv[i]);
    wr_reg(ADDR_CTRL, 32'h4);
    rd_reg(ADDR_CTRL, 32'h4);
    $display("test reset_values done");
    for (int i = 0; i < 4; i++)
    begin
      wr_reg(ADDR_LANES, {28'h0, lc[i]});
      fb_burst(6, i > 1, i[0]);
      repeat (6) @(posedge clock);
    end
    $display("test lane_configs done");
    fork
      fb_burst(10, 1'b1, 1'b0);
      begin
        repeat (4) @(posedge clock);
        wr_reg(ADDR_CTRL, 32'h5);
      end
    join
    repeat (6) @(posedge clock);
    fb_burst(8, 1'b0, 1'b1);
    repeat (10) @(posedge clock);
    `CHK(conv_n, 8 / D)
    wr_reg(ADDR_CTRL, 32'h4);
    repeat (4) @(posedge clock);
    fb_burst(4, 1'b1, 1'b0);
    $display("test feedback_sink done");
    wr_reg(ADDR_LANES, 32'h0);
    wr_reg(ADDR_CTRL, 32'h2);
    bb_n = 0;
    for (int i = 0; i < 16; i++) far.send(0, $urandom());
    far.stop();
    repeat (12) @(posedge clock);
    `CHK(bb_n, 16 / (D * D))
    boot_lane_sel <= 1'b1;
    repeat (20) @(posedge clock);
    wr_reg(ADDR_CTRL, 32'h20);
    @(posedge clock);
    `CHK(net_sync, 2'b11)
    rd_reg(ADDR_STATUS, 32'h13);
    `CHK(dma_stream_data, 32'h13)
    `CHK(dma_stream_valid, 1'b0)
    boot_lane_sel <= 1'b0;
    $display("test receive_and_lanes done");
    sr_n = 0;
    far.pulse();
    repeat (6) @(posedge clock);
    `CHK(sr_n, 1)
    wr_reg(ADDR_CTRL, 32'h8);
    repeat (1100) @(posedge clock);
    `CHK(sr_n > 2, 1'b1)
    $display("test sysref done");
    wr_reg(ADDR_CTRL, 32'h4);
    wr_reg(ADDR_IRQ_SEL, 32'h18);
    wr_reg(ADDR_LANES, 32'h6);
    repeat (6) @(posedge clock);
    `CHK(irq, 2'b01)
    far.set_sync(2'b10);
    repeat (8) @(posedge clock);
    `CHK(irq, 2'b11)
    far.set_sync(2'b11);
    wr_reg(ADDR_LANES, 32'h0);
    repeat (8) @(posedge clock);
    `CHK(irq, 2'b00)
    `CHK(cq.size(), 0)
    $display("test interrupts done");
    wrap_up();
  end
endmodule : rx_route_tb_top
bind rx_route rx_route_assertions #(.W(W), .LANES(LANES)) chk (
  .clock(clock), .rst(rst), .rd(rd), .rdata(rdata), .boot_lane_sel(boot_lane_sel),
  .rx_lane_data(rx_lane_data), .rx_lane_valid(rx_lane_valid),
  .tx_stream_data(tx_stream_data), .tx_lane_data(tx_lane_data),
  .antenna_lane_port_rx(antenna_lane_port_rx),
  .antenna_lane_port_to_net(antenna_lane_port_to_net), .capture_data(capture_data),
  .capture_valid(capture_valid), .conv_valid(conv_valid), .conv_src(conv_src),
  .baseband_sample_valid(baseband_sample_valid)
);
